// ### hw/fdoc_top.sv
// digital output control register and drive pin logic
// assumes a synchronous 8-bit register port and power-down input
// Function
// - four-drive pin meanings only when four_drive_select_cfg is 1
// - eight internal selects and enables encode onto four pins
// - with select enable low, encoded pins carry selected drive number
// - motor decode enable low lets decoder drive one motor enable
// - in power-down the motor bits are held off and the reset bit held 0, keeping the core in reset, except on a waking write
// - power-down keeps dma gate and drive select unchanged
// - writes in power-down do not wake unless a motor bit set
// - dma gate 1 enables request, ack, terminal count, interrupt
// - dma gate 0 tri-states interrupt and request, ignores ack and tc
// - gated terminal count still reaches other units
// - soft reset bit 0 clears controller core and fifo; only the fifo clear is lock-gated
// - hard reset clears soft reset bit; core stays reset until set
// - soft reset leaves rate, config registers and other bits alone
// - bits 1:0 select drive; motor may run without select
// - matching motor and select: encoded select, both enables low
// - no match: lowest motor, select enable high; none: all high
`timescale 1ns/1ns
module fdoc_top
(
  // clock and hard bus reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // configuration and power
  input  wire logic       four_drive_select_cfg,
  input  wire logic       power_down,
  input  wire logic       lock_bit,
  output logic            wake_req,
  // controller core side
  input  wire logic       core_dma_req,
  input  wire logic       core_irq,
  input  wire logic       floppy_dma_ack_n,
  input  wire logic       tc_in,
  output logic            core_reset,
  output logic            core_fifo_reset,
  output logic            core_ack_n,
  output logic            core_tc,
  output logic            other_unit_tc,
  // bus request outputs with enables
  output logic            floppy_dma_request,
  output logic            floppy_dma_request_oe,
  output logic            irq6_out,
  output logic            irq6_oe,
  // drive pins
  output logic            encoded_select_hi,
  output logic            encoded_select_lo,
  output logic            select_decode_enable_n,
  output logic            motor_decode_enable_n
);

  typedef struct packed {
    fdoc_pkg::fdoc_ctrl_s ctrl;
    logic [7:0]           rdata;
    logic                 wake;
  } fdoc_state_s;

  fdoc_state_s          st_ff;
  fdoc_state_s          nxt_st;
  fdoc_pkg::fdoc_pins_s pins;
  logic                 hit;

  assign hit = reg_addr == fdoc_pkg::OFS_OUT_CTRL;

  // ****************************************
  // register state
  // ****************************************
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.wake = 1'b0;
    if (hit && reg_wr)
    begin
      nxt_st.ctrl = reg_wdata;
      if (power_down && reg_wdata[7:4] != 4'h0)
      begin
        nxt_st.wake = 1'b1;
      end
    end
    if (power_down && !nxt_st.wake)
    begin
      nxt_st.ctrl.motor_on       = 4'h0;
      nxt_st.ctrl.soft_reset_bit = 1'b0;
    end
    nxt_st.rdata = (hit && reg_rd) ? nxt_st.ctrl : 8'h00;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '{ctrl: fdoc_pkg::OUT_CTRL_RST, rdata: 8'h00, wake: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign wake_req  = st_ff.wake;

  // ****************************************
  // soft reset and dma gating
  // ****************************************
  assign core_reset      = ~st_ff.ctrl.soft_reset_bit;
  assign core_fifo_reset = ~st_ff.ctrl.soft_reset_bit & ~lock_bit;

  assign floppy_dma_request    = core_dma_req;
  assign floppy_dma_request_oe = st_ff.ctrl.dma_gate_bit;
  assign irq6_out              = core_irq;
  assign irq6_oe               = st_ff.ctrl.dma_gate_bit;
  assign core_ack_n            = st_ff.ctrl.dma_gate_bit ? floppy_dma_ack_n : 1'b1;
  assign core_tc               = st_ff.ctrl.dma_gate_bit & tc_in;
  assign other_unit_tc         = tc_in;

  // ****************************************
  // drive pins
  // ****************************************
  fdoc_encode u_enc
  (
    .ctrl                  (st_ff.ctrl),
    .four_drive_select_cfg (four_drive_select_cfg),
    .pins                  (pins)
  );

  assign encoded_select_hi      = pins.encoded_select_hi;
  assign encoded_select_lo      = pins.encoded_select_lo;
  assign select_decode_enable_n = pins.select_decode_enable_n;
  assign motor_decode_enable_n  = pins.motor_decode_enable_n;

  // ****************************************
  // checks
  // ****************************************
  a_pd_motor_off: assert property (@(posedge clk) disable iff (rst)
    power_down && !(hit && reg_wr) |=> st_ff.ctrl.motor_on == 4'h0)
    else $error("motor bits active in power-down");
  a_pd_keep_sel: assert property (@(posedge clk) disable iff (rst)
    power_down && !(hit && reg_wr) |=> $stable(st_ff.ctrl.unit_select_field))
    else $error("select changed in power-down");
  a_wake_motor: assert property (@(posedge clk) disable iff (rst)
    power_down && hit && reg_wr && reg_wdata[7:4] != 4'h0 |=> wake_req)
    else $error("no wake on motor write");
  a_no_wake: assert property (@(posedge clk) disable iff (rst)
    hit && reg_wr && reg_wdata[7:4] == 4'h0 |=> !wake_req)
    else $error("wake without motor bit");
  a_dma_gate_off: assert property (@(posedge clk) disable iff (rst)
    !st_ff.ctrl.dma_gate_bit |-> !irq6_oe && !floppy_dma_request_oe && !core_tc && core_ack_n)
    else $error("dma lines not gated");
  a_tc_other: assert property (@(posedge clk) disable iff (rst)
    other_unit_tc == tc_in)
    else $error("tc blocked to other units");
  a_soft_reset: assert property (@(posedge clk) disable iff (rst)
    hit && reg_wr && !reg_wdata[2] |=> core_reset)
    else $error("core not reset");
  a_match_pins: assert property (@(posedge clk) disable iff (rst)
    four_drive_select_cfg && st_ff.ctrl.motor_on[st_ff.ctrl.unit_select_field]
    |-> {encoded_select_hi, encoded_select_lo} == st_ff.ctrl.unit_select_field
        && !select_decode_enable_n && !motor_decode_enable_n)
    else $error("matched select pins wrong");
  a_none_pins: assert property (@(posedge clk) disable iff (rst)
    four_drive_select_cfg && st_ff.ctrl.motor_on == 4'h0
    |-> encoded_select_hi && encoded_select_lo && select_decode_enable_n && motor_decode_enable_n)
    else $error("idle pins not high");

endmodule

// ### hw/fdoc_pkg.sv
// package for the four-drive output control block
// assumes one 20 MHz clock and an 8-bit register port
package fdoc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] OFS_OUT_CTRL  = 3'h2;
  localparam logic [7:0] OUT_CTRL_RST  = 8'h00;
  localparam int         BIT_DMA_GATE  = 3;
  localparam int         BIT_SOFT_RST  = 2;
  localparam int         MOTOR_LSB     = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int         CLK_MHZ       = 20;
  localparam int         SRST_MIN_NS   = 500;
  localparam int         SRST_MIN_CYC  = (SRST_MIN_NS * CLK_MHZ + 999) / 1000;

  // ****************************************
  // register contents
  // ****************************************
  typedef struct packed {
    logic [3:0] motor_on;
    logic       dma_gate_bit;
    logic       soft_reset_bit;
    logic [1:0] unit_select_field;
  } fdoc_ctrl_s;

  typedef struct packed {
    logic encoded_select_hi;
    logic encoded_select_lo;
    logic select_decode_enable_n;
    logic motor_decode_enable_n;
  } fdoc_pins_s;

endpackage

// ### hw/fdoc_encode.sv
// drive pin encoder for two- and four-drive modes
// assumes control fields are already registered
`timescale 1ns/1ns
module fdoc_encode
(
  // control
  input  wire fdoc_pkg::fdoc_ctrl_s ctrl,
  input  wire logic                 four_drive_select_cfg,
  // pins
  output fdoc_pkg::fdoc_pins_s      pins
);

  logic [1:0] lowest;
  logic       match;

  // ****************************************
  // lowest enabled motor
  // ****************************************
  always_comb
  begin
    lowest = 2'h3;
    for (int i = 3; i >= 0; i--)
    begin
      if (ctrl.motor_on[i])
      begin
        lowest = 2'(i);
      end
    end
  end

  assign match = ctrl.motor_on[ctrl.unit_select_field];

  always_comb
  begin
    if (four_drive_select_cfg)
    begin
      if (ctrl.motor_on == 4'h0)
      begin
        pins = 4'hf;
      end
      else if (match)
      begin
        pins = {ctrl.unit_select_field, 1'b0, 1'b0};
      end
      else
      begin
        pins = {lowest, 1'b1, 1'b0};
      end
    end
    else
    begin
      // two-drive: select_n pair, motor_n pair
      pins.encoded_select_hi      = ~(ctrl.unit_select_field == 2'h1);
      pins.encoded_select_lo      = ~(ctrl.unit_select_field == 2'h0);
      pins.select_decode_enable_n = ~ctrl.motor_on[1];
      pins.motor_decode_enable_n  = ~ctrl.motor_on[0];
    end
  end

endmodule

// ### bench/fdoc_ext_decoder.sv
// external decoder that turns the four encoded pins into drive strobes
// assumes the block drives the pins in four-drive mode
`timescale 1ns/1ns
module fdoc_ext_decoder
(
  // encoded pins
  input  wire logic       encoded_select_hi,
  input  wire logic       encoded_select_lo,
  input  wire logic       select_decode_enable_n,
  input  wire logic       motor_decode_enable_n,
  // per-drive strobes, active low
  output logic      [3:0] unit_sel_n,
  output logic      [3:0] motor_n
);
  logic [3:0] one_hot;

  // ************************************
  // decode
  // ************************************
  assign one_hot    = 4'h1 << {encoded_select_hi, encoded_select_lo};
  assign unit_sel_n = select_decode_enable_n ? 4'hf : ~one_hot;
  assign motor_n    = motor_decode_enable_n ? 4'hf : ~one_hot;
endmodule

// ### bench/tb_top.sv
// testbench for the four-drive output control block
// assumes fdoc_top and fdoc_ext_decoder are compiled first
`timescale 1ns/1ns
module tb_top;
  logic       clk, rst, reg_wr, reg_rd, four_drive_select_cfg, power_down, lock_bit, wake_req;
  logic       core_dma_req, core_irq, floppy_dma_ack_n, tc_in, core_reset, core_fifo_reset, core_ack_n;
  logic       core_tc, other_unit_tc, floppy_dma_request, floppy_dma_request_oe, irq6_out, irq6_oe;
  logic       encoded_select_hi, encoded_select_lo, select_decode_enable_n, motor_decode_enable_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, e;
  logic [3:0] unit_sel_n, motor_n;
  int         miscompares, comparisons;

  fdoc_top fdoc_top_i (.clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .four_drive_select_cfg,
    .power_down, .lock_bit, .wake_req, .core_dma_req, .core_irq, .floppy_dma_ack_n, .tc_in, .core_reset,
    .core_fifo_reset, .core_ack_n, .core_tc, .other_unit_tc, .floppy_dma_request, .floppy_dma_request_oe,
    .irq6_out, .irq6_oe, .encoded_select_hi, .encoded_select_lo, .select_decode_enable_n, .motor_decode_enable_n);
  fdoc_ext_decoder fdoc_ext_decoder_i (.encoded_select_hi, .encoded_select_lo, .select_decode_enable_n,
    .motor_decode_enable_n, .unit_sel_n, .motor_n);

  // ************************************
  // helpers
  // ************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) #5;
    reg_wr    = 1'h1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk) #5;
    reg_wr = 1'h0;
  endtask
  task automatic rd(input string what, input logic [7:0] exp);
    @(posedge clk) #5;
    reg_rd   = 1'h1;
    reg_addr = 3'h2;
    @(posedge clk) #5;
    reg_rd = 1'h0;
    chk(what, exp, reg_rdata);
  endtask
  function automatic logic [7:0] exp_pins(input logic [7:0] r);
    if (r[7:4] == 4'h0) return 8'h0f;
    if (r[4 + r[1:0]]) return {4'h0, r[1:0], 2'h0};
    return {4'h0, r[4] ? 2'h0 : r[5] ? 2'h1 : r[6] ? 2'h2 : 2'h3, 2'h2};
  endfunction

  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset;
    rd("register", 8'h00);
    chk("pins", 8'h0f, {4'h0, encoded_select_hi, encoded_select_lo, select_decode_enable_n, motor_decode_enable_n});
    chk("resets oe", 8'h0c, {4'h0, core_reset, core_fifo_reset, floppy_dma_request_oe, irq6_oe});
    wr(3'h2, 8'h1c);
    chk("boot drive", 8'hee, {unit_sel_n, motor_n});
    $display("done t_reset");
  endtask
  task automatic t_table;
    for (int r = 0; r < 256; r++)
    begin
      wr(3'h2, 8'(r) | 8'h0c);
      e = exp_pins(8'(r));
      chk("pins", e, {4'h0, encoded_select_hi, encoded_select_lo, select_decode_enable_n, motor_decode_enable_n});
      chk("decoded", {e[1] ? 4'hf : ~(4'h1 << e[3:2]), e[0] ? 4'hf : ~(4'h1 << e[3:2])}, {unit_sel_n, motor_n});
    end
    rd("last", 8'hff);
    $display("done t_table");
  endtask
  task automatic t_dma;
    wr(3'h2, 8'h04);
    chk("gated", 8'h05, {3'h0, floppy_dma_request_oe, irq6_oe, core_ack_n, core_tc, other_unit_tc});
    wr(3'h2, 8'h0c);
    chk("open", 8'h7b, {1'h0, floppy_dma_request, irq6_out, floppy_dma_request_oe, irq6_oe, core_ack_n, core_tc,
      other_unit_tc});
    $display("done t_dma");
  endtask
  task automatic t_srst;
    wr(3'h2, 8'h3f);
    chk("run", 8'h00, {6'h0, core_reset, core_fifo_reset});
    wr(3'h2, 8'h3b);
    chk("held", 8'h03, {6'h0, core_reset, core_fifo_reset});
    lock_bit = 1'h1;
    @(posedge clk) #5;
    chk("locked", 8'h02, {6'h0, core_reset, core_fifo_reset});
    lock_bit = 1'h0;
    rd("others kept", 8'h3b);
    repeat (fdoc_pkg::SRST_MIN_CYC) @(posedge clk);
    $display("done t_srst");
  endtask
  task automatic t_pd;
    wr(3'h2, 8'h1d);
    power_down = 1'h1;
    @(posedge clk) #5;
    rd("powered down", 8'h09);
    wr(3'h2, 8'h09);
    chk("no wake", 8'h00, {7'h0, wake_req});
    wr(3'h2, 8'h2d);
    chk("wake", 8'h01, {7'h0, wake_req});
    power_down = 1'h0;
    rd("woken", 8'h2d);
    $display("done t_pd");
  endtask
  task automatic t_two;
    four_drive_select_cfg = 1'h0;
    @(posedge clk) #5;
    chk("two drive", 8'h05, {4'h0, encoded_select_hi, encoded_select_lo, select_decode_enable_n,
      motor_decode_enable_n});
    four_drive_select_cfg = 1'h1;
    wr(3'h3, 8'hff);
    rd("unmapped", 8'h2d);
    $display("done t_two");
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ************************************
  // run
  // ************************************
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    rst                   = 1'h1;
    reg_wr                = 1'h0;
    reg_rd                = 1'h0;
    reg_addr              = 3'h2;
    reg_wdata             = 8'h00;
    four_drive_select_cfg = 1'h1;
    power_down            = 1'h0;
    lock_bit              = 1'h0;
    core_dma_req          = 1'h1;
    core_irq              = 1'h1;
    floppy_dma_ack_n      = 1'h0;
    tc_in                 = 1'h1;
    repeat (20) @(posedge clk);
    #5 rst = 1'h0;
    t_reset();
    t_table();
    t_dma();
    t_srst();
    t_pd();
    t_two();
    print_verdict();
  end
endmodule
